// ==== hdl/osc_ctrl_map.vh ====
// register map, field layout, mode codes and counts of the clock select controller
// assumes a 32-bit apb with byte addresses and word-aligned registers
`ifndef OSC_CTRL_MAP_VH
`define OSC_CTRL_MAP_VH

`define ADDR_OSC_CONTROL 12'h000
`define ADDR_TUNE_SRC 12'h004
`define ADDR_CLK_STATUS 12'h008

`define OSC_CONTROL_RST 8'h30
`define TUNE_SRC_RST 8'h00
`define BIT_IDLE_ON_SLEEP 7
`define FLD_FREQ_HI 6
`define FLD_FREQ_LO 4
`define BIT_PRIMARY_RUNNING 3
`define BIT_HF_STABLE 2
`define FLD_SEL_HI 1
`define FLD_SEL_LO 0
`define BIT_LOW_FREQ_SRC 0
`define BIT_SEC_RUNNING 0
`define BIT_CLK_FAIL 1

`define SEL_PRIMARY 2'h0
`define SEL_SECONDARY 2'h1
`define FREQ_LOWEST 3'h0
`define FREQ_DIRECT 3'h7
`define DIV_LOG2_512 4'h9

`define MODE_LP 4'h0
`define MODE_XT 4'h1
`define MODE_HS 4'h2
`define MODE_HIGH_SPEED_MULTIPLIED_MODE 4'h3
`define MODE_RC 4'h4
`define MODE_RC_WITH_IO_MODE 4'h5
`define MODE_INTERNAL_CLKOUT_MODE 4'h6
`define MODE_INTERNAL_IO_MODE 4'h7
`define MODE_EC 4'h8
`define MODE_EXTERNAL_CLOCK_IO_MODE 4'h9

`define SRC_PRIMARY 2'h0
`define SRC_SECONDARY 2'h1
`define SRC_INTERNAL 2'h2

`define SWITCH_GAP 2'h2
`define FAIL_TICKS 4'h8

`endif

// ==== hdl/osc_ctrl.v ====
// system clock source selection, internal postscaler control and status
// assumes all inputs synchronous to pclk; oscillators themselves live outside
// Operation
// (R1) four-bit configuration field picks one of ten primary clock modes
// (R2) select field: 1x internal block, 01 secondary oscillator, 00 primary
// (R3) any reset clears the select field, choosing the primary clock
// (R4) after a select write the source changes following a short transition
// (R5) frequency field picks 16 MHz down to 31 kHz through the postscaler
// (R6) frequency writes change the internal output at once
// (R7) frequency field resets to 1 MHz
// (R8) at lowest code, source bit picks hf divided by 512 or lf oscillator
// (R9) watchdog and fail monitor always run from the lf oscillator
// (R10) primary running flag shows primary clock in use; reset depends on two-speed (here it resets to 0 either way)
// (R11) hf stable flag shows the hf oscillator is stable
// (R12) select 00 with internal primary mode sets both status flags
// (R13) select not 00: at most one of three running flags set
// (R14) sleep instruction enters idle when idle bit set, else full sleep
// (R15) secondary not enabled: keep previous source until enable is set
// (R16) software should start the secondary oscillator before selecting it
// (R17) fail monitor catches lost external clock and moves to internal
// (R18) rc, internal and ec modes drive clock/4 on pin one; io variants free it
// (R19) source switches gate the clock off before changing the mux
// (R20) writes to the two status flags are ignored
//
// The address map and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "osc_ctrl_map.vh"

module osc_ctrl
(
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // configuration and oscillator state
    input wire [3:0] primary_mode_sel,
    input wire two_speed_startup_cfg,
    input wire primary_ready,
    input wire primary_activity,
    input wire hf_stable,
    input wire lf_tick,
    input wire sec_osc_enable,
    input wire sleep_exec,
    // clock mux and postscaler control
    output reg [1:0] clk_src_sel,
    output reg clk_gate_en,
    output reg [3:0] int_div_log2,
    output reg int_use_lf,
    output reg sec_clk_running,
    output reg clk_fail,
    output reg wdt_tick,
    // power management
    output reg idle_enter,
    output reg sleep_enter,
    // first oscillator pin
    output reg osc_pin_one_out,
    output reg osc_pin_one_oe
);

    localparam ST_RUN = 2'h0;
    localparam ST_GAP = 2'h1;
    localparam ST_SWAP = 2'h2;

    reg [7:0] osc_control_r;
    reg low_freq_src_r;
    reg [1:0] state_r;
    reg [1:0] gap_cnt_r;
    reg [1:0] last_ok_src_r;
    reg act_prev_r;
    reg [3:0] fail_cnt_r;
    reg [1:0] clkout_cnt_r;
    reg [1:0] target_nxt;
    reg [3:0] div_nxt;
    reg [31:0] rdata_nxt;
    reg addr_ok_nxt;
    reg primary_run_nxt;
    reg hf_flag_nxt;

    wire [1:0] sel_w = osc_control_r[`FLD_SEL_HI:`FLD_SEL_LO];
    wire [2:0] freq_w = osc_control_r[`FLD_FREQ_HI:`FLD_FREQ_LO];
    wire wr_en = psel & penable & pready & pwrite;
    wire wr_ctl = wr_en & (paddr == `ADDR_OSC_CONTROL);
    wire wr_tune = wr_en & (paddr == `ADDR_TUNE_SRC);

    // mode classes of the primary clock
    wire mode_internal = (primary_mode_sel == `MODE_INTERNAL_CLKOUT_MODE) |
                         (primary_mode_sel == `MODE_INTERNAL_IO_MODE); // R1
    wire mode_clkout = (primary_mode_sel == `MODE_RC) |
                       (primary_mode_sel == `MODE_INTERNAL_CLKOUT_MODE) |
                       (primary_mode_sel == `MODE_EC); // R18
    // unlisted codes are not internal modes, drive no clock out and are never monitored
    wire mode_monitored = (primary_mode_sel <= `MODE_EXTERNAL_CLOCK_IO_MODE) & ~mode_internal; // R17

    wire hf_in_use = (clk_src_sel == `SRC_INTERNAL) |
                     ((clk_src_sel == `SRC_PRIMARY) & mode_internal);
    wire hf_providing = hf_in_use & ~((freq_w == `FREQ_LOWEST) & ~low_freq_src_r);

    // status next values; with a non-primary select only one bit may show,
    // even while an internal primary still runs during or instead of a switch
    always @*
    begin
        primary_run_nxt = (clk_src_sel == `SRC_PRIMARY) &
            (mode_internal | primary_ready) & ~clk_fail; // R10 R12
        hf_flag_nxt = hf_stable & hf_providing; // R11 R12
        if (primary_run_nxt & (sel_w != `SEL_PRIMARY))
        begin
            hf_flag_nxt = 1'b0; // R13
        end
    end

    // target source
    always @*
    begin
        if (sel_w[1])
        begin
            target_nxt = `SRC_INTERNAL; // R2
        end
        else if (sel_w == `SEL_SECONDARY)
        begin
            // stay on the last source until the timer oscillator is on
            target_nxt = sec_osc_enable ? `SRC_SECONDARY : last_ok_src_r; // R15
        end
        else if (clk_fail)
        begin
            target_nxt = `SRC_INTERNAL; // R17
        end
        else if (two_speed_startup_cfg & ~mode_internal & ~primary_ready)
        begin
            target_nxt = `SRC_INTERNAL;
        end
        else
        begin
            target_nxt = `SRC_PRIMARY; // R2
        end
    end

    // postscaler tap: codes 7..1 divide 16 MHz by 2^(7-code)
    always @*
    begin
        if (freq_w == `FREQ_LOWEST)
        begin
            div_nxt = low_freq_src_r ? `DIV_LOG2_512 : 4'h0; // R8
        end
        else
        begin
            div_nxt = {1'b0, `FREQ_DIRECT - freq_w}; // R5
        end
    end

    // source switch: gate off, wait, swap, gate on
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= ST_RUN;
            gap_cnt_r <= 2'h0;
            clk_src_sel <= `SRC_PRIMARY; // R3
            last_ok_src_r <= `SRC_PRIMARY;
            clk_gate_en <= 1'b1;
        end
        else
        begin
            case (state_r)
                ST_RUN:
                begin
                    if (target_nxt != clk_src_sel)
                    begin
                        // old clock stops first so no runt reaches the system
                        clk_gate_en <= 1'b0; // R19
                        gap_cnt_r <= 2'h0;
                        state_r <= ST_GAP; // R4
                    end
                end
                ST_GAP:
                begin
                    gap_cnt_r <= gap_cnt_r + 2'h1;
                    if (gap_cnt_r == `SWITCH_GAP - 2'h1)
                    begin
                        clk_src_sel <= target_nxt; // R4
                        state_r <= ST_SWAP;
                    end
                end
                ST_SWAP:
                begin
                    clk_gate_en <= 1'b1; // R19
                    if (clk_src_sel != `SRC_SECONDARY)
                    begin
                        last_ok_src_r <= clk_src_sel;
                    end
                    state_r <= ST_RUN;
                end
                default:
                begin
                    state_r <= ST_RUN;
                    clk_gate_en <= 1'b1;
                end
            endcase
        end
    end

    // software registers
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            osc_control_r <= `OSC_CONTROL_RST; // R3 R7
            low_freq_src_r <= 1'b0;
        end
        else
        begin
            if (wr_ctl)
            begin
                osc_control_r[`BIT_IDLE_ON_SLEEP] <= pwdata[`BIT_IDLE_ON_SLEEP];
                osc_control_r[`FLD_FREQ_HI:`FLD_FREQ_LO] <=
                    pwdata[`FLD_FREQ_HI:`FLD_FREQ_LO]; // R6
                osc_control_r[`FLD_SEL_HI:`FLD_SEL_LO] <= pwdata[`FLD_SEL_HI:`FLD_SEL_LO];
            end
            // status bits are hardware owned
            osc_control_r[`BIT_PRIMARY_RUNNING] <= primary_run_nxt; // R10 R12 R13 R20
            osc_control_r[`BIT_HF_STABLE] <= hf_flag_nxt; // R11 R12 R13 R20
            if (wr_tune)
            begin
                low_freq_src_r <= pwdata[`BIT_LOW_FREQ_SRC];
            end
        end
    end

    // fail monitor on the lf tick, independent of the source bit
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            act_prev_r <= 1'b0;
            fail_cnt_r <= 4'h0;
            clk_fail <= 1'b0;
            wdt_tick <= 1'b0;
        end
        else
        begin
            act_prev_r <= primary_activity;
            wdt_tick <= lf_tick; // R9
            if (primary_activity != act_prev_r)
            begin
                fail_cnt_r <= 4'h0;
            end
            else if (lf_tick & (fail_cnt_r != `FAIL_TICKS))
            begin
                fail_cnt_r <= fail_cnt_r + 4'h1; // R9
            end
            // detection wins over a select write in the same cycle
            if (mode_monitored & primary_ready & (fail_cnt_r == `FAIL_TICKS))
            begin
                clk_fail <= 1'b1; // R17
            end
            else if (wr_ctl)
            begin
                clk_fail <= 1'b0;
            end
        end
    end

    // outputs: postscaler, status, sleep, clock out pin
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            int_div_log2 <= 4'h0;
            int_use_lf <= 1'b0;
            sec_clk_running <= 1'b0;
            idle_enter <= 1'b0;
            sleep_enter <= 1'b0;
            clkout_cnt_r <= 2'h0;
            osc_pin_one_out <= 1'b0;
            osc_pin_one_oe <= 1'b0;
        end
        else
        begin
            int_div_log2 <= div_nxt; // R6
            int_use_lf <= (freq_w == `FREQ_LOWEST) & ~low_freq_src_r; // R8
            sec_clk_running <= (clk_src_sel == `SRC_SECONDARY) & clk_gate_en; // R13
            idle_enter <= sleep_exec & osc_control_r[`BIT_IDLE_ON_SLEEP]; // R14
            sleep_enter <= sleep_exec & ~osc_control_r[`BIT_IDLE_ON_SLEEP]; // R14
            clkout_cnt_r <= clkout_cnt_r + 2'h1;
            // pclk stands for the system clock here, so clkout is pclk/4
            osc_pin_one_out <= mode_clkout & clkout_cnt_r[1]; // R18
            osc_pin_one_oe <= mode_clkout; // R18
        end
    end

    // read mux and decode
    always @*
    begin
        rdata_nxt = 32'h0;
        addr_ok_nxt = 1'b1;
        case (paddr)
            `ADDR_OSC_CONTROL:
            begin
                rdata_nxt[7:0] = osc_control_r;
            end
            `ADDR_TUNE_SRC:
            begin
                rdata_nxt[`BIT_LOW_FREQ_SRC] = low_freq_src_r;
            end
            `ADDR_CLK_STATUS:
            begin
                rdata_nxt[`BIT_SEC_RUNNING] = sec_clk_running;
                rdata_nxt[`BIT_CLK_FAIL] = clk_fail;
            end
            default:
            begin
                addr_ok_nxt = 1'b0;
            end
        endcase
    end

    // no wait state: answer is registered during the setup cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_ok_nxt;
            if (psel & ~penable & ~pwrite)
            begin
                prdata <= rdata_nxt;
            end
        end
    end

endmodule

`default_nettype wire

// ==== sim/osc_ctrl_monitor.sv ====
// port assertions for the clock select controller
// assumes it is bound onto osc_ctrl
`timescale 1ns/1ps
`default_nettype none
`include "osc_ctrl_map.vh"
module osc_ctrl_monitor
(
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic [11:0] paddr,
    // oscillator side
    input wire logic [3:0] primary_mode_sel,
    input wire logic lf_tick,
    input wire logic sec_osc_enable,
    input wire logic sleep_exec,
    input wire logic [1:0] clk_src_sel,
    input wire logic clk_gate_en,
    input wire logic clk_fail,
    input wire logic wdt_tick,
    input wire logic idle_enter,
    input wire logic sleep_enter,
    input wire logic osc_pin_one_out,
    input wire logic osc_pin_one_oe
);
    // keeps $past from seeing values held over a reset
    reg up_r;
    wire clkout = primary_mode_sel == `MODE_RC || primary_mode_sel == `MODE_INTERNAL_CLKOUT_MODE
        || primary_mode_sel == `MODE_EC;
    wire wr_ctl = psel && penable && pready && pwrite && paddr == `ADDR_OSC_CONTROL;
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            up_r <= 1'b0;
        else
            up_r <= 1'b1;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence gate_drop;
        $fell(clk_gate_en);
    endsequence
    sequence mux_then_run;
        ##2 $changed(clk_src_sel) ##1 clk_gate_en;
    endsequence
    AST_SWITCH_STEPS: assert property (gate_drop |-> mux_then_run)
        else $error("switch steps out of order");
    AST_MUX_GATED: assert property (up_r && $changed(clk_src_sel) |-> !clk_gate_en)
        else $error("mux moved while clock ran");
    AST_SEC_ENABLED: assert property (up_r && $changed(clk_src_sel)
        && clk_src_sel == `SRC_SECONDARY |-> $past(sec_osc_enable))
        else $error("secondary taken while disabled");
    AST_SLEEP_PICK: assert property (sleep_exec |=> idle_enter != sleep_enter)
        else $error("sleep gave no single mode");
    AST_WDT_LF: assert property (up_r |-> wdt_tick == $past(lf_tick))
        else $error("watchdog tick lost");
    AST_FAIL_HOLD: assert property (clk_fail && !wr_ctl |=> clk_fail)
        else $error("fail flag dropped");
    AST_FAIL_INT: assert property ($rose(clk_fail)
        |-> ##[1:8] clk_src_sel == `SRC_INTERNAL)
        else $error("no move to internal");
    AST_PIN_OE: assert property (up_r && $stable(primary_mode_sel)
        |-> osc_pin_one_oe == clkout)
        else $error("pin drive wrong");
    AST_PIN_QUIET: assert property (!osc_pin_one_oe |-> !osc_pin_one_out)
        else $error("freed pin still toggles");
endmodule
bind osc_ctrl osc_ctrl_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
    .paddr, .primary_mode_sel, .lf_tick, .sec_osc_enable, .sleep_exec, .clk_src_sel,
    .clk_gate_en, .clk_fail, .wdt_tick, .idle_enter, .sleep_enter, .osc_pin_one_out,
    .osc_pin_one_oe);
`default_nettype wire

// ==== sim/ext_osc_model.sv ====
// model of the external clock source and the slow internal oscillator
// assumes pclk as timebase; alive low stops the external clock
`timescale 1ns/1ps
`default_nettype none
module ext_osc_model
(
    // timebase and control
    input wire logic pclk,
    input wire logic presetn,
    input wire logic alive,
    // oscillator state
    output logic primary_ready,
    output logic primary_activity,
    output logic lf_tick
);
    logic [2:0] cnt_r;
    assign lf_tick = cnt_r == 3'h7;
    always @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            cnt_r <= 3'h0;
            primary_ready <= 1'b0;
            primary_activity <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_r + 3'h1;
            primary_ready <= 1'b1;
            // a stopped source freezes the line instead of floating
            primary_activity <= alive ? ~primary_activity : primary_activity;
        end
endmodule
`default_nettype wire

// ==== sim/test_system_clock_select_control.sv ====
// self-checking bench for the clock select controller
// assumes design, monitor and oscillator model compiled first
`timescale 1ns/1ps
`default_nettype none
`include "osc_ctrl_map.vh"
module test_system_clock_select_control;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, alive = 1;
    logic sec_osc_enable = 0, sleep_exec = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rng = 32'hcff3;
    logic [3:0] primary_mode_sel = `MODE_LP;
    logic [32:0] expq[$];
    int err_count = 0, n_compared = 0, k;
    wire [31:0] prdata;
    wire [1:0] src;
    wire [3:0] div;
    wire pready, pslverr, rdy, act, lft, lf, fail, idl, slp, oe, pin;
    logic pin_prev;
    osc_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .primary_mode_sel, .two_speed_startup_cfg(1'b0),
        .primary_ready(rdy), .primary_activity(act), .hf_stable(rdy), .lf_tick(lft),
        .sec_osc_enable, .sleep_exec, .clk_src_sel(src), .clk_gate_en(), .int_div_log2(div),
        .int_use_lf(lf), .sec_clk_running(), .clk_fail(fail), .wdt_tick(), .idle_enter(idl),
        .sleep_enter(slp), .osc_pin_one_out(pin), .osc_pin_one_oe(oe));
    ext_osc_model osc (.pclk, .presetn, .alive, .primary_ready(rdy), .primary_activity(act),
        .lf_tick(lft));
    initial
        forever
            #10 pclk = ~pclk;
    task summarize;
        $display("errors %0d compared %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task cmp(input logic [32:0] got, input logic [32:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch %0t got %h want %h", $time, got, exp);
        end
    endtask
    task tmo;
        err_count++;
        $display("mismatch %0t wait ran out", $time);
        summarize;
    endtask
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
        int i;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w)
            expq.push_back(e);
        @(posedge pclk);
        penable <= 1;
        for (i = 0; i == 0 || (pready !== 1'b1 && i < 8); i++)
            @(posedge pclk);
        if (pready !== 1'b1)
            tmo;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task wsrc(input logic [1:0] s);
        int i;
        for (i = 0; i < 200 && src !== s; i++)
            @(posedge pclk);
        if (src !== s)
            tmo;
        cmp(src, s);
    endtask
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1 && !pwrite)
            cmp({pslverr, prdata}, expq.pop_front());
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        repeat (4) @(posedge pclk);
        cmp({src, div}, {`SEL_PRIMARY, 4'h4});
        apb(0, `ADDR_OSC_CONTROL, 0, 33'h38);
        for (k = 7; k > 0; k--)
        begin
            apb(1, `ADDR_OSC_CONTROL, {k[2:0], 4'h2}, 0);
            @(posedge pclk);
            cmp(div, 33'(7 - k));
        end
        wsrc(`SRC_INTERNAL);
        apb(1, `ADDR_OSC_CONTROL, 32'h02, 0);
        @(posedge pclk);
        cmp(lf, 1);
        apb(1, `ADDR_TUNE_SRC, 1, 0);
        @(posedge pclk);
        cmp({lf, div}, {1'b0, `DIV_LOG2_512});
        apb(1, `ADDR_OSC_CONTROL, 32'hfe, 0);
        apb(0, `ADDR_OSC_CONTROL, 0, 33'hf6);
        for (k = 0; k < 2; k++)
        begin
            apb(1, `ADDR_OSC_CONTROL, {~k[0], 7'h72}, 0);
            sleep_exec <= 1;
            @(posedge pclk);
            sleep_exec <= 0;
            @(posedge pclk);
            cmp({idl, slp}, k ? 2'b01 : 2'b10);
        end
        apb(1, `ADDR_OSC_CONTROL, 32'h01, 0);
        repeat (8) @(posedge pclk);
        cmp(src, `SRC_INTERNAL);
        sec_osc_enable <= 1;
        wsrc(`SRC_SECONDARY);
        // running flag trails the mux by the gate cycle
        @(posedge pclk);
        apb(0, `ADDR_CLK_STATUS, 0, 33'h1);
        apb(1, `ADDR_OSC_CONTROL, 0, 0);
        wsrc(`SRC_PRIMARY);
        repeat (3)
        begin
            rng = xs(rng);
            apb(1, `ADDR_OSC_CONTROL, {rng[7:4], 4'h0}, 0);
            apb(0, `ADDR_OSC_CONTROL, 0, {rng[7:4], 4'h8});
        end
        apb(0, 12'h00c, 0, {1'b1, 32'h0});
        alive <= 0;
        wsrc(`SRC_INTERNAL);
        cmp(fail, 1);
        alive <= 1;
        // resumed activity restarts the count first, so the clear is not overridden by detection
        repeat (3) @(posedge pclk);
        apb(1, `ADDR_OSC_CONTROL, 0, 0);
        cmp(fail, 0);
        wsrc(`SRC_PRIMARY);
        for (k = 0; k < 10; k++)
        begin
            primary_mode_sel <= k[3:0];
            repeat (2) @(posedge pclk);
            cmp(oe, k == 4 || k == 6 || k == 8);
        end
        primary_mode_sel <= `MODE_INTERNAL_CLKOUT_MODE;
        sec_osc_enable <= 0;
        repeat (2) @(posedge pclk);
        // pclk/4 gives 8 level changes in 16 cycles at any phase
        pin_prev = pin;
        k = 0;
        repeat (16)
        begin
            @(posedge pclk);
            k += (pin != pin_prev);
            pin_prev = pin;
        end
        cmp(k, 8);
        apb(0, `ADDR_OSC_CONTROL, 0, 33'h0c);
        apb(1, `ADDR_OSC_CONTROL, 32'h01, 0);
        repeat (4) @(posedge pclk);
        cmp(src, `SRC_PRIMARY);
        apb(0, `ADDR_OSC_CONTROL, 0, 33'h09);
        apb(1, `ADDR_OSC_CONTROL, 32'h72, 0);
        wsrc(`SRC_INTERNAL);
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        repeat (2) @(posedge pclk);
        cmp(src, `SRC_PRIMARY);
        apb(0, `ADDR_OSC_CONTROL, 0, 33'h3c);
        summarize;
    end
endmodule
`default_nettype wire
